// file: lpc_pkg.sv
// Behaviour
// - Ready/busy pin mirrors status bit 7 in A/A mux mode, held high otherwise
// - Master lowers frame to start or abort
// - Decode lines whenever frame strobe is active
// - Release lines next edge after frame seen
// - Accept only memory read and write
// - Master supplies the shared bus clock
// - Reset or init low: deselect, float, halt
// - Hold reset low at least minimum time
// - Leave reset in read-array mode, all locked
// - Wait wake time and output-valid time
// - Reset during busy aborts, adds latency
// - Assert device reset on every platform reset
// - Start code 0000b on last frame-low edge
// - Cycle type 010x read, 011x write
// - Turnaround: 1111b one clock, then float
// - Short-wait 0101b until ready, then 0000b
package lpc_pkg;
   localparam int       CLK_PERIOD_NS            = 40;
   localparam int       RESET_LOW_MIN_TIME_NS    = 100;
   localparam int       RESET_WAKE_TIME_NS       = 1000;
   localparam int       RESET_OUTPUT_VALID_TIME_NS = 1000;
   localparam int       RESET_LATENCY_NS         = 20000;
   localparam int       RESET_LOW_CYC   = (RESET_LOW_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int       RESET_WAKE_CYC  = (RESET_WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int       RESET_VALID_CYC = (RESET_OUTPUT_VALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int       RESET_LATENCY_CYC = (RESET_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int       SYNC_TIMEOUT_CYC = 64;
   localparam int       ABORT_CYC        = 4;
   localparam int       ADDR_NIBBLES     = 8;
   localparam int       STATUS_READY_BIT = 7;
   localparam int       MEM_SPACE_BIT    = 23;
   localparam int       ID_LSB           = 20;
   localparam int       SECTORS          = 16;
   localparam logic [3:0] START_CODE     = 4'h0;
   localparam logic [2:0] TYPE_MEM_RD    = 3'h2;
   localparam logic [2:0] TYPE_MEM_WR    = 3'h3;
   localparam logic [3:0] TAR_CODE       = 4'hf;
   localparam logic [3:0] WAIT_SYNC_CODE  = 4'h5;
   localparam logic [3:0] READY_SYNC_CODE = 4'h0;
   localparam logic [3:0] ABORT_CODE     = 4'hf;
   localparam logic [3:0] IDLE_CODE      = 4'hf;

   function automatic logic is_mem_cycle(input logic [3:0] nib);
      return (nib[3:1] == TYPE_MEM_RD) || (nib[3:1] == TYPE_MEM_WR);
   endfunction
endpackage

// file: lpc_link_if.sv
`timescale 1ns/1ps
interface lpc_link_if;
   logic [3:0] lad;
   logic [3:0] host_lad;
   logic       host_lad_oe_n;
   logic [3:0] dev_lad;
   logic       dev_lad_oe_n;
   logic       frame_n;
   logic       reset_n;
   logic       init_n;

   // Pull-ups hold the lines high when nobody drives
   assign lad = !host_lad_oe_n ? host_lad : (!dev_lad_oe_n ? dev_lad : 4'hf);

   modport device (input lad, frame_n, reset_n, init_n, output dev_lad, dev_lad_oe_n);
   modport host   (input lad, output host_lad, host_lad_oe_n, frame_n, reset_n, init_n);
endinterface

// file: lpc_reset_ctrl.sv
`timescale 1ns/1ps
module lpc_reset_ctrl
   import lpc_pkg::*;
(
   // Clock and resets
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic reset_n_i,
   input  wire logic init_n_i,
   // Core status
   input  wire logic busy_i,
   input  wire logic latency_clr_i,
   // Reset outputs
   output logic      core_rst_o,
   output logic      abort_o,
   output logic      latency_o
);
   typedef struct packed {
      logic [1:0] ok_sync;
      logic       latency;
   } rst_state_s;

   rst_state_s state_reg;
   rst_state_s state_next;
   logic       hold_now;

   assign hold_now   = rst_i | ~reset_n_i | ~init_n_i;
   // Assert at once, release only after the pins are synchronised
   assign core_rst_o = hold_now | ~state_reg.ok_sync[1];
   assign abort_o    = hold_now & busy_i;
   assign latency_o  = state_reg.latency;

   always_comb begin
      state_next = state_reg;
      state_next.ok_sync = {state_reg.ok_sync[0], reset_n_i & init_n_i};
      if (latency_clr_i) begin
         state_next.latency = 1'b0;
      end
      if (!state_reg.ok_sync[1] && busy_i) begin
         state_next.latency = 1'b1;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule

// file: lpc_flash_target.sv
`timescale 1ns/1ps
module lpc_flash_target
   import lpc_pkg::*;
#(
   parameter logic [2:0] DEVICE_ID   = 3'h0,
   parameter int         WAKE_CYC    = RESET_WAKE_CYC,
   parameter int         VALID_CYC   = RESET_VALID_CYC,
   parameter int         LATENCY_CYC = RESET_LATENCY_CYC
)
(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // Bus link
   lpc_link_if.device       link,
   // Flash core side
   input  wire logic [7:0]  status_i,
   input  wire logic        aamux_mode_i,
   input  wire logic        mem_ack_i,
   input  wire logic [7:0]  mem_rdata_i,
   output logic             mem_rd_o,
   output logic             mem_wr_o,
   output logic [19:0]      mem_addr_o,
   output logic [7:0]       mem_wdata_o,
   output logic             core_abort_o,
   output logic             read_array_o,
   output logic [SECTORS-1:0] sector_locked_o,
   output logic             ready_busy_pin_o
);
   // Windows must fit the 12-bit uptime counter, which saturates
   if (WAKE_CYC + LATENCY_CYC > 4095 || VALID_CYC + LATENCY_CYC > 4095 || WAKE_CYC < 1) begin : g_bad_counts
      $error("lpc_flash_target: reset counts out of range");
   end

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_TYPE  = 3'b001,
      ST_ADDR  = 3'b010,
      ST_WDATA = 3'b011,
      ST_HTAR  = 3'b100,
      ST_SYNC  = 3'b101,
      ST_RDATA = 3'b110,
      ST_DTAR  = 3'b111
   } dev_state_e;

   typedef struct packed {
      dev_state_e          st;
      logic [2:0]          cnt;
      logic                wr;
      logic [31:0]         addr;
      logic [7:0]          wdata;
      logic [7:0]          rdata;
      logic                ack_seen;
      logic [3:0]          dout;
      logic                oe_n;
      logic                rd_pulse;
      logic                wr_pulse;
      logic [11:0]         up_cnt;
      logic                mode_pulse;
      logic                first;
      logic [SECTORS-1:0]  locks;
      logic                rb;
   } dev_s;

   dev_s        s_reg;
   dev_s        s_next;
   logic        core_rst;
   logic        latency;
   logic [11:0] extra;
   logic        wake_ok;
   logic        valid_ok;
   logic [31:0] addr_sh;
   logic        hit;

   lpc_reset_ctrl u_reset (
      .clock_i       (clock_i),
      .rst_i         (rst_i),
      .reset_n_i     (link.reset_n),
      .init_n_i      (link.init_n),
      .busy_i        (~status_i[STATUS_READY_BIT]),
      .latency_clr_i (wake_ok & valid_ok),
      .core_rst_o    (core_rst),
      .abort_o       (core_abort_o),
      .latency_o     (latency)
   );

   // An aborted program or erase stretches both post-reset windows
   assign extra    = latency ? 12'(LATENCY_CYC) : 12'h000;
   assign wake_ok  = s_reg.up_cnt >= 12'(WAKE_CYC) + extra;
   assign valid_ok = s_reg.up_cnt >= 12'(VALID_CYC) + extra;
   assign addr_sh  = {s_reg.addr[27:0], link.lad};
   assign hit      = addr_sh[MEM_SPACE_BIT] && (addr_sh[ID_LSB +: 3] == DEVICE_ID);

   assign link.dev_lad      = s_reg.dout;
   assign link.dev_lad_oe_n = s_reg.oe_n;
   assign mem_rd_o          = s_reg.rd_pulse;
   assign mem_wr_o          = s_reg.wr_pulse;
   assign mem_addr_o        = s_reg.addr[19:0];
   assign mem_wdata_o       = s_reg.wdata;
   assign read_array_o      = s_reg.mode_pulse;
   assign sector_locked_o   = s_reg.locks;
   assign ready_busy_pin_o  = s_reg.rb;

   always_comb begin
      s_next            = s_reg;
      s_next.rd_pulse   = 1'b0;
      s_next.wr_pulse   = 1'b0;
      s_next.first      = 1'b0;
      s_next.mode_pulse = s_reg.first;
      s_next.rb         = aamux_mode_i ? status_i[STATUS_READY_BIT] : 1'b1;
      if (s_reg.up_cnt != 12'hfff) begin
         s_next.up_cnt = s_reg.up_cnt + 12'h001;
      end
      // Late ack still counts; the start of a new cycle clears it
      if (mem_ack_i) begin
         s_next.ack_seen = 1'b1;
         s_next.rdata    = mem_rdata_i;
      end
      case (s_reg.st)
         ST_IDLE: begin
            s_next.oe_n = 1'b1;
         end
         ST_TYPE: begin
            s_next.wr  = link.lad[1];
            s_next.cnt = 3'h0;
            s_next.st  = is_mem_cycle(link.lad) ? ST_ADDR : ST_IDLE;
         end
         ST_ADDR: begin
            s_next.addr = addr_sh;
            s_next.cnt  = s_reg.cnt + 3'h1;
            if (s_reg.cnt == 3'(ADDR_NIBBLES - 1)) begin
               s_next.cnt = 3'h0;
               if (!hit || (s_reg.wr && !wake_ok)) begin
                  s_next.st = ST_IDLE;
               end else if (s_reg.wr) begin
                  s_next.st = ST_WDATA;
               end else begin
                  s_next.st       = ST_HTAR;
                  s_next.rd_pulse = 1'b1;
               end
            end
         end
         ST_WDATA: begin
            s_next.cnt = 3'h1;
            if (s_reg.cnt == 3'h0) begin
               s_next.wdata[3:0] = link.lad;
            end else begin
               s_next.wdata[7:4] = link.lad;
               s_next.cnt        = 3'h0;
               s_next.st         = ST_HTAR;
            end
         end
         ST_HTAR: begin
            s_next.cnt = 3'h1;
            if (s_reg.cnt == 3'h1) begin
               s_next.st   = ST_SYNC;
               s_next.oe_n = 1'b0;
               s_next.cnt  = 3'h0;
               if (s_reg.wr) begin
                  // Array write only once the master has handed over the bus
                  s_next.wr_pulse = 1'b1;
                  s_next.dout     = READY_SYNC_CODE;
               end else begin
                  s_next.dout = (s_reg.ack_seen && valid_ok) ? READY_SYNC_CODE : WAIT_SYNC_CODE;
               end
            end
         end
         ST_SYNC: begin
            if (s_reg.dout == READY_SYNC_CODE) begin
               s_next.st   = s_reg.wr ? ST_DTAR : ST_RDATA;
               s_next.dout = s_reg.wr ? TAR_CODE : s_reg.rdata[3:0];
            end else begin
               s_next.dout = (s_reg.ack_seen && valid_ok) ? READY_SYNC_CODE : WAIT_SYNC_CODE;
            end
         end
         ST_RDATA: begin
            s_next.cnt = 3'h1;
            if (s_reg.cnt == 3'h0) begin
               s_next.dout = s_reg.rdata[7:4];
            end else begin
               s_next.cnt  = 3'h0;
               s_next.dout = TAR_CODE;
               s_next.st   = ST_DTAR;
            end
         end
         ST_DTAR: begin
            s_next.oe_n = 1'b1;
            s_next.st   = ST_IDLE;
         end
         default: begin
            s_next.st   = ST_IDLE;
            s_next.oe_n = 1'b1;
         end
      endcase
      // Frame low overrides all but the read strobe: drop the cycle and watch for a start
      if (!link.frame_n) begin
         s_next.oe_n     = 1'b1;
         s_next.wr_pulse = 1'b0;
         s_next.ack_seen = 1'b0;
         s_next.st       = (link.lad == START_CODE) ? ST_TYPE : ST_IDLE;
      end
   end

   always_ff @(posedge clock_i or posedge core_rst) begin
      if (core_rst) begin
         s_reg       <= '0;
         s_reg.st    <= ST_IDLE;
         s_reg.dout  <= IDLE_CODE;
         s_reg.oe_n  <= 1'b1;
         s_reg.first <= 1'b1;
         s_reg.locks <= '1;
         s_reg.rb    <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// file: lpc_bus_host.sv
`timescale 1ns/1ps
module lpc_bus_host
   import lpc_pkg::*;
#(
   parameter int RESET_CYC   = RESET_LOW_CYC,
   parameter int TIMEOUT_CYC = SYNC_TIMEOUT_CYC
)
(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // Bus link
   lpc_link_if.host         link,
   // Request side
   input  wire logic        req_i,
   input  wire logic        wr_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        init_req_i,
   output logic             ready_o,
   output logic             done_o,
   output logic             timeout_o,
   output logic [7:0]       rdata_o
);
   if (RESET_CYC < 1 || RESET_CYC > 255 || TIMEOUT_CYC < 1 || TIMEOUT_CYC > 255) begin : g_bad_counts
      $error("lpc_bus_host: counts out of range");
   end

   typedef enum logic [3:0] {
      HS_IDLE  = 4'b0000,
      HS_START = 4'b0001,
      HS_TYPE  = 4'b0010,
      HS_ADDR  = 4'b0011,
      HS_WDATA = 4'b0100,
      HS_TAR   = 4'b0101,
      HS_TAR2  = 4'b0110,
      HS_SYNC  = 4'b0111,
      HS_RDATA = 4'b1000,
      HS_DTAR  = 4'b1001,
      HS_ABORT = 4'b1010
   } host_state_e;

   typedef struct packed {
      host_state_e st;
      logic [7:0]  cnt;
      logic        wr;
      logic [31:0] sh;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic [3:0]  lad;
      logic        oe_n;
      logic        frame_n;
      logic        done;
      logic        tmo;
      logic [7:0]  hold;
      logic        init_only;
   } host_s;

   host_s s_reg;
   host_s s_next;

   assign ready_o            = (s_reg.st == HS_IDLE) && (s_reg.hold == 8'h00);
   assign done_o             = s_reg.done;
   assign timeout_o          = s_reg.tmo;
   assign rdata_o            = s_reg.rdata;
   assign link.host_lad      = s_reg.lad;
   assign link.host_lad_oe_n = s_reg.oe_n;
   assign link.frame_n       = s_reg.frame_n;
   // Platform reset reaches the device; init alone pulses only init
   assign link.reset_n       = (s_reg.hold == 8'h00) || s_reg.init_only;
   assign link.init_n        = (s_reg.hold == 8'h00) || !s_reg.init_only;

   always_comb begin
      s_next         = s_reg;
      s_next.done    = 1'b0;
      s_next.tmo     = 1'b0;
      s_next.frame_n = 1'b1;
      s_next.cnt     = s_reg.cnt + 8'h01;
      if (s_reg.hold != 8'h00) begin
         s_next.hold = s_reg.hold - 8'h01;
      end
      case (s_reg.st)
         HS_IDLE: begin
            s_next.oe_n = 1'b1;
            if (init_req_i && s_reg.hold == 8'h00) begin
               s_next.hold      = 8'(RESET_CYC);
               s_next.init_only = 1'b1;
            end else if (req_i && ready_o) begin
               s_next.st      = HS_START;
               s_next.wr      = wr_i;
               s_next.sh      = addr_i;
               s_next.wdata   = wdata_i;
               s_next.frame_n = 1'b0;
               s_next.oe_n    = 1'b0;
               s_next.lad     = START_CODE;
            end
         end
         HS_START: begin
            s_next.st  = HS_TYPE;
            s_next.lad = {s_reg.wr ? TYPE_MEM_WR : TYPE_MEM_RD, 1'b0};
         end
         HS_TYPE: begin
            s_next.st  = HS_ADDR;
            s_next.cnt = 8'h00;
            s_next.lad = s_reg.sh[31:28];
            s_next.sh  = {s_reg.sh[27:0], 4'h0};
         end
         HS_ADDR: begin
            s_next.lad = s_reg.sh[31:28];
            s_next.sh  = {s_reg.sh[27:0], 4'h0};
            if (s_reg.cnt == 8'(ADDR_NIBBLES - 1)) begin
               s_next.cnt = 8'h00;
               s_next.st  = s_reg.wr ? HS_WDATA : HS_TAR;
               s_next.lad = s_reg.wr ? s_reg.wdata[3:0] : TAR_CODE;
            end
         end
         HS_WDATA: begin
            s_next.lad = s_reg.wdata[7:4];
            if (s_reg.cnt == 8'h01) begin
               s_next.st  = HS_TAR;
               s_next.lad = TAR_CODE;
            end
         end
         HS_TAR: begin
            s_next.oe_n = 1'b1;
            s_next.st   = HS_TAR2;
         end
         HS_TAR2: begin
            s_next.st  = HS_SYNC;
            s_next.cnt = 8'h00;
         end
         HS_SYNC: begin
            if (link.lad == READY_SYNC_CODE) begin
               s_next.st  = s_reg.wr ? HS_DTAR : HS_RDATA;
               s_next.cnt = 8'h00;
            end else if (s_reg.cnt == 8'(TIMEOUT_CYC - 1)) begin
               // A silent or stuck target must not hang the bus
               s_next.st      = HS_ABORT;
               s_next.cnt     = 8'h00;
               s_next.frame_n = 1'b0;
               s_next.oe_n    = 1'b0;
               s_next.lad     = ABORT_CODE;
            end
         end
         HS_RDATA: begin
            if (s_reg.cnt == 8'h00) begin
               s_next.rdata[3:0] = link.lad;
            end else begin
               s_next.rdata[7:4] = link.lad;
               s_next.st         = HS_DTAR;
               s_next.cnt        = 8'h00;
            end
         end
         HS_DTAR: begin
            if (s_reg.cnt == 8'h01) begin
               s_next.st   = HS_IDLE;
               s_next.done = 1'b1;
            end
         end
         HS_ABORT: begin
            s_next.frame_n = 1'b0;
            if (s_reg.cnt == 8'(ABORT_CYC - 2)) begin
               s_next.frame_n = 1'b1;
               s_next.lad     = IDLE_CODE;
            end else if (s_reg.cnt == 8'(ABORT_CYC - 1)) begin
               s_next.frame_n = 1'b1;
               s_next.oe_n    = 1'b1;
               s_next.st      = HS_IDLE;
               s_next.tmo     = 1'b1;
            end
         end
         default: begin
            s_next.st   = HS_IDLE;
            s_next.oe_n = 1'b1;
         end
      endcase
      if (s_reg.hold == 8'h01) begin
         s_next.init_only = 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg         <= '0;
         s_reg.st      <= HS_IDLE;
         s_reg.oe_n    <= 1'b1;
         s_reg.frame_n <= 1'b1;
         s_reg.lad     <= IDLE_CODE;
         s_reg.hold    <= 8'(RESET_CYC);
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// file: lpc_link_checker.sv
`timescale 1ns/1ps
module lpc_link_checker
   import lpc_pkg::*;
(
   // Clock and reset
   input logic       clock_i,
   input logic       rst_i,
   // Link signals
   input logic [3:0] lad,
   input logic [3:0] host_lad,
   input logic       host_lad_oe_n,
   input logic [3:0] dev_lad,
   input logic       dev_lad_oe_n,
   input logic       frame_n,
   input logic       reset_n,
   input logic       init_n
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   property p_release; !frame_n |=> dev_lad_oe_n; endproperty
   a_release: assert property (p_release) else $error("device kept lines after frame");
   property p_rst_float; !reset_n || !init_n |-> dev_lad_oe_n; endproperty
   a_rst_float: assert property (p_rst_float) else $error("device drives in reset");
   property p_host_tar; $rose(host_lad_oe_n) |-> $past(host_lad) == TAR_CODE && dev_lad_oe_n; endproperty
   a_host_tar: assert property (p_host_tar) else $error("host release without 1111");
   // Releases forced by frame or reset skip the 1111 clock
   property p_dev_tar;
      $rose(dev_lad_oe_n) && $past(frame_n) && reset_n && init_n |-> $past(dev_lad) == TAR_CODE;
   endproperty
   a_dev_tar: assert property (p_dev_tar) else $error("device release without 1111");
   property p_dev_take; $fell(dev_lad_oe_n) |-> $past(host_lad_oe_n) && !$past(host_lad_oe_n, 2); endproperty
   a_dev_take: assert property (p_dev_take) else $error("device drive not after float clock");
   property p_sync_first;
      $fell(dev_lad_oe_n) |-> dev_lad == WAIT_SYNC_CODE || dev_lad == READY_SYNC_CODE;
   endproperty
   a_sync_first: assert property (p_sync_first) else $error("first device nibble not a sync");
   property p_wait_next;
      !dev_lad_oe_n && dev_lad == WAIT_SYNC_CODE |=>
         dev_lad_oe_n || dev_lad == WAIT_SYNC_CODE || dev_lad == READY_SYNC_CODE;
   endproperty
   a_wait_next: assert property (p_wait_next) else $error("wait sync not followed by sync");
   property p_start;
      $fell(frame_n) |-> !host_lad_oe_n && (host_lad == START_CODE || host_lad == ABORT_CODE);
   endproperty
   a_start: assert property (p_start) else $error("frame low without start or abort");
   property p_type; !frame_n && lad == START_CODE ##1 frame_n |-> lad[3:2] == 2'b01; endproperty
   a_type: assert property (p_type) else $error("cycle type not memory");
   c_read: cover property (!frame_n && lad == START_CODE ##1 lad[3:1] == TYPE_MEM_RD);
   c_write: cover property (!frame_n && lad == START_CODE ##1 lad[3:1] == TYPE_MEM_WR);
   c_abort: cover property (!frame_n && lad == ABORT_CODE);
endmodule

// file: lpc_flash_target_frontend_tb.sv
`timescale 1ns/1ps
module lpc_flash_target_frontend_tb;
   import lpc_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        req_i = 1'b0;
   logic        wr_i = 1'b0;
   logic        init_req_i = 1'b0;
   logic [31:0] addr_i = 32'h0;
   logic [7:0]  wdata_i = 8'h0;
   logic [7:0]  status_i = 8'h80;
   logic        aamux_mode_i = 1'b1;
   logic        mem_ack_i = 1'b0;
   logic [7:0]  mem_rdata_i = 8'h0;
   logic        ready_o, done_o, timeout_o, mem_rd_o, mem_wr_o, read_array_o, ready_busy_pin_o, core_abort_o, wr2;
   logic [7:0]  rdata_o, mem_wdata_o, last_wd;
   logic [19:0] mem_addr_o, last_wa;
   logic [15:0] sector_locked_o;
   int          miscompares = 0, n_tests = 0, cyc = 0, wcnt = 0, ra_cnt = 0, w2 = 0, d2 = 0, ack_dly = 0;
   lpc_link_if u_link();
   lpc_link_if u_link2();
   lpc_bus_host i_lpc_bus_host (.clock_i(clock_i), .rst_i(rst_i), .link(u_link.host), .req_i(req_i), .wr_i(wr_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .init_req_i(init_req_i), .ready_o(ready_o), .done_o(done_o),
      .timeout_o(timeout_o), .rdata_o(rdata_o));
   // Latency long enough that the first write after a busy reset lands before wake
   lpc_flash_target #(.DEVICE_ID(3'h5), .WAKE_CYC(2), .VALID_CYC(2), .LATENCY_CYC(40)) i_lpc_flash_target (
      .clock_i(clock_i), .rst_i(rst_i), .link(u_link.device), .status_i(status_i), .aamux_mode_i(aamux_mode_i),
      .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .core_abort_o(core_abort_o),
      .read_array_o(read_array_o), .sector_locked_o(sector_locked_o), .ready_busy_pin_o(ready_busy_pin_o));
   // Second target faces a scripted master that breaks cycles on purpose
   lpc_flash_target #(.DEVICE_ID(3'h5)) i_lpc_flash_target_2 (.clock_i(clock_i), .rst_i(rst_i),
      .link(u_link2.device), .status_i(status_i), .aamux_mode_i(aamux_mode_i), .mem_ack_i(mem_ack_i),
      .mem_rdata_i(mem_rdata_i), .mem_rd_o(), .mem_wr_o(wr2), .mem_addr_o(), .mem_wdata_o(), .core_abort_o(),
      .read_array_o(), .sector_locked_o(), .ready_busy_pin_o());
   lpc_link_checker i_lpc_link_checker (.clock_i(clock_i), .rst_i(rst_i), .lad(u_link.lad),
      .host_lad(u_link.host_lad), .host_lad_oe_n(u_link.host_lad_oe_n), .dev_lad(u_link.dev_lad),
      .dev_lad_oe_n(u_link.dev_lad_oe_n), .frame_n(u_link.frame_n), .reset_n(u_link.reset_n),
      .init_n(u_link.init_n));

   function automatic logic [7:0] exp_rd(input logic [19:0] a);
      return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
   endfunction

   task automatic tally_and_finish();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_bit(input string n, input logic e, input logic g);
      chk_val(n, {31'h0, e}, {31'h0, g});
   endtask

   task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, input logic ok);
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      @(posedge clock_i);
      req_i <= 1'b1;
      wr_i <= w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      req_i <= 1'b0;
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (done_o !== 1'b1 && timeout_o !== 1'b1 && n < 300);
      chk_bit("done", ok, done_o);
      chk_bit("timeout", !ok, timeout_o);
      if (ok && !w) chk_val("rdata", exp_rd(a[19:0]), rdata_o);
   endtask

   task automatic drv2(input logic [63:0] nib, input logic [15:0] fr, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock_i);
         u_link2.frame_n <= fr[i];
         u_link2.host_lad_oe_n <= 1'b0;
         u_link2.host_lad <= nib[63-4*i -: 4];
      end
      @(posedge clock_i);
      u_link2.frame_n <= 1'b1;
      u_link2.host_lad_oe_n <= 1'b1;
      repeat (30) @(posedge clock_i);
   endtask

   always #20 clock_i = ~clock_i;

   // Core stand-in: answers reads after a random delay
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (mem_wr_o === 1'b1) begin
         wcnt <= wcnt + 1;
         last_wa <= mem_addr_o;
         last_wd <= mem_wdata_o;
      end
      if (read_array_o === 1'b1) ra_cnt <= ra_cnt + 1;
      if (wr2 === 1'b1) w2 <= w2 + 1;
      if (u_link2.dev_lad_oe_n === 1'b0) d2 <= d2 + 1;
      mem_ack_i <= 1'b0;
      if (mem_rd_o === 1'b1) ack_dly <= $urandom_range(4, 1);
      else if (ack_dly > 0) ack_dly <= ack_dly - 1;
      if (ack_dly == 1) begin
         mem_ack_i <= 1'b1;
         mem_rdata_i <= exp_rd(mem_addr_o);
      end
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial begin
      logic [31:0] a;
      logic [7:0]  d;
      logic        w;
      int          n;
      void'($urandom(32'hab156cac));
      u_link2.host_lad = 4'hf;
      u_link2.host_lad_oe_n = 1'b1;
      u_link2.frame_n = 1'b1;
      u_link2.reset_n = 1'b1;
      u_link2.init_n = 1'b1;
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (40) @(negedge clock_i);
      chk_val("locks", 16'hffff, sector_locked_o);
      chk_val("read_array", 1, ra_cnt);
      for (int i = 0; i < 6; i++) begin
         @(posedge clock_i);
         status_i <= 8'($urandom);
         aamux_mode_i <= (i < 4);
         repeat (3) @(negedge clock_i);
         chk_bit("ready_busy", (i < 4) ? status_i[7] : 1'b1, ready_busy_pin_o);
      end
      @(posedge clock_i);
      status_i <= 8'h80;
      aamux_mode_i <= 1'b1;
      // Every sixth cycle is register space, the one before it another id
      for (int i = 0; i < 24; i++) begin
         a = {8'hff, 4'hd, 20'($urandom)};
         if (i < 2) a[19:0] = {20{i[0]}};
         if (i % 6 == 5) a[23] = 1'b0;
         if (i % 6 == 4) a[22:20] = 3'h2;
         d = 8'($urandom);
         w = 1'($urandom);
         n = wcnt;
         xfer(w, a, d, i % 6 < 4);
         repeat (2) @(negedge clock_i);
         chk_val("writes", n + (w && i % 6 < 4), wcnt);
         if (w && i % 6 < 4) chk_val("wdata", {a[19:0], d}, {last_wa, last_wd});
      end
      @(posedge clock_i);
      status_i <= 8'h00;
      init_req_i <= 1'b1;
      @(posedge clock_i);
      init_req_i <= 1'b0;
      n = 0;
      while (u_link.init_n !== 1'b0 && n < 20) begin
         @(negedge clock_i);
         n++;
      end
      chk_bit("abort", 1'b1, core_abort_o);
      chk_bit("float", 1'b1, u_link.dev_lad_oe_n);
      // Core stays busy until the synchronised pins are low, so the latency is taken
      repeat (4) @(posedge clock_i);
      status_i <= 8'h80;
      repeat (20) @(negedge clock_i);
      chk_val("locks", 16'hffff, sector_locked_o);
      chk_val("read_array", 2, ra_cnt);
      xfer(1'b1, 32'hffd12345, 8'h3c, 1'b0);
      xfer(1'b1, 32'hffd12345, 8'h3c, 1'b1);
      xfer(1'b0, 32'hffd12345, 8'h00, 1'b1);
      drv2(64'h06ffd00000a5ff00, 16'hcffe, 14);
      drv2(64'h00ffd00000f00000, 16'hfffe, 11);
      chk_val("dropped_write", 0, w2);
      chk_val("foreign_drive", 0, d2);
      tally_and_finish();
   end
endmodule
